// File: hw/tmw_pkg.sv
package tmw_pkg;
    // register addresses (word indices on the plain port)
    localparam logic [3:0] ADDR_MODE = 4'h0;    // timer_mode_select
    localparam logic [3:0] ADDR_CTRL = 4'h1;    // timer_clock_clear_level_control
    localparam logic [3:0] ADDR_IEN = 4'h2;     // timer_interrupt_enables
    localparam logic [3:0] ADDR_STAT = 4'h3;    // timer_status_reg
    localparam logic [3:0] ADDR_CNT_H = 4'h4;   // timer_count high byte
    localparam logic [3:0] ADDR_CNT_L = 4'h5;   // timer_count low byte
    localparam logic [3:0] ADDR_GR_BASE = 4'h8; // general_reg a..d, hi/lo pairs from 8
    // mode register fields
    localparam int MODE_START = 7;
    localparam int MODE_BUF_B = 5;
    localparam int MODE_BUF_A = 4;
    localparam int MODE_PWM_D = 2;
    localparam int MODE_PWM_C = 1;
    localparam int MODE_PWM_B = 0;
    localparam logic [7:0] MODE_FIXED_ONES = 8'h48;
    localparam logic [7:0] MODE_WR_MASK = 8'hb7;
    // control register fields
    localparam int CTRL_CLEAR = 7;
    localparam int CTRL_CKS_HI = 6;
    localparam int CTRL_CKS_LO = 4;
    // enable / status register fields
    localparam int IEN_OVF = 7;
    localparam logic [7:0] IEN_FIXED_ONES = 8'h70;
    localparam logic [7:0] IEN_WR_MASK = 8'h8f;
    // clock select codes
    localparam logic [2:0] CKS_DIV1 = 3'h0;
    localparam logic [2:0] CKS_DIV2 = 3'h1;
    localparam logic [2:0] CKS_DIV4 = 3'h2;
    localparam logic [2:0] CKS_DIV8 = 3'h3;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] GR_RESET = 16'hffff;
endpackage

// File: hw/tmw_prescaler.sv
`timescale 1ns/1ps
// free-running divider giving one-cycle enables at /2, /4, /8
module tmw_prescaler
    import tmw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    output logic en2,
    output logic en4,
    output logic en8
);
    logic [2:0] div_r; // divider chain

    // count every cycle; a lower bit set pattern marks the tick
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    assign en2 = div_r[0];
    assign en4 = &div_r[1:0];
    assign en8 = &div_r;
endmodule // tmw_prescaler

// File: hw/tmw_timer.sv
`timescale 1ns/1ps
module tmw_timer
    import tmw_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    input wire logic externalEventIn,
    input wire logic subClockTick,
    input wire logic subMode,
    output logic [3:0] timerPin,
    output logic overflowIrqReq,
    output logic [3:0] chanIrqReq
);
    logic [7:0] mode_r;        // mode register storage bits
    logic [7:0] ctrl_r;        // control register
    logic [7:0] ien_r;         // interrupt enables (writable bits)
    logic overflowFlag_r;      // overflow status
    logic [3:0] matchFlag_r;   // per-channel match status
    logic [4:0] armed_r;       // flag seen set by a read, bit 4 = overflow
    logic [15:0] count_r;      // timer_count
    logic [15:0] genReg_r [4]; // general_reg a..d, compare values
    logic [3:0] pinLatch_r;    // pin output latches
    logic [1:0] evSync_r;      // external event synchroniser
    logic evPrev_r;            // previous synced event level
    logic [1:0] subSync_r;     // subclock tick synchroniser
    logic subPrev_r;
    logic [1:0] subModeSync_r; // low-power mode level sync
    logic en2, en4, en8;
    logic countTick;           // one-cycle advance enable
    logic [3:0] match;         // compare hits this cycle
    logic wrap;                // overflow event
    logic [2:0] clkSel;
    logic [7:0] stat;          // status image

    tmw_prescaler u_pre (
        .mclk(mclk),
        .rst(rst),
        .en2(en2),
        .en4(en4),
        .en8(en8)
    );

    // pin inputs pass two flops before use
    always_ff @(posedge mclk) begin
        if (rst) begin
            evSync_r <= 2'h0;
            evPrev_r <= 1'b0;
            subSync_r <= 2'h0;
            subPrev_r <= 1'b0;
            subModeSync_r <= 2'h0;
        end else begin
            evSync_r <= {evSync_r[0], externalEventIn};
            evPrev_r <= evSync_r[1];
            subSync_r <= {subSync_r[0], subClockTick};
            subPrev_r <= subSync_r[1];
            subModeSync_r <= {subModeSync_r[0], subMode};
        end
    end

    assign clkSel = ctrl_r[CTRL_CKS_HI:CTRL_CKS_LO];

    // count enable by clock source
    always_comb begin
        countTick = 1'b0;
        if (clkSel[2]) begin
            countTick = evSync_r[1] & ~evPrev_r;
        end else begin
            case (clkSel[1:0])
                CKS_DIV1[1:0]: begin
                    // low-power modes run from the slow subclock instead
                    if (subModeSync_r[1]) begin
                        countTick = subSync_r[1] & ~subPrev_r;
                    end else begin
                        countTick = 1'b1;
                    end
                end
                CKS_DIV2[1:0]: countTick = en2;
                CKS_DIV4[1:0]: countTick = en4;
                CKS_DIV8[1:0]: countTick = en8;
                default: countTick = 1'b0;
            endcase
        end
        countTick = countTick & mode_r[MODE_START];
    end

    // compare on the current count, qualified by the advance tick
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cmp
            assign match[gi] = countTick && (count_r == genReg_r[gi]);
        end
    endgenerate

    assign wrap = countTick && (count_r == CNT_MAX) && !(ctrl_r[CTRL_CLEAR] && match[0]);

    // counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_r <= 16'h0000;
        end else if (wrStb && addr == ADDR_CNT_H) begin
            count_r[15:8] <= wrData;
        end else if (wrStb && addr == ADDR_CNT_L) begin
            count_r[7:0] <= wrData;
        end else if (countTick) begin
            if (ctrl_r[CTRL_CLEAR] && match[0]) begin
                count_r <= 16'h0000;
            end else begin
                count_r <= count_r + 16'h0001; // free-running, wraps
            end
        end
    end

    // general registers, byte-written
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                genReg_r[i] <= GR_RESET;
            end
        end else if (wrStb && addr >= ADDR_GR_BASE) begin
            if (addr[0]) begin
                genReg_r[addr[2:1]][7:0] <= wrData;
            end else begin
                genReg_r[addr[2:1]][15:8] <= wrData;
            end
        end
    end

    // control registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_r <= 8'h00;
            ctrl_r <= 8'h00;
            ien_r <= 8'h00;
        end else if (wrStb) begin
            if (addr == ADDR_MODE) mode_r <= wrData & MODE_WR_MASK;
            if (addr == ADDR_CTRL) ctrl_r <= wrData;
            if (addr == ADDR_IEN) ien_r <= wrData & IEN_WR_MASK;
        end
    end

    // pin latches: level write loads, matches act afterwards
    // per the mode control register, a normal channel toggles on match
    // and a PWM channel sets on match and resets at match A (period)
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinLatch_r <= 4'h0;
        end else if (wrStb && addr == ADDR_CTRL) begin
            pinLatch_r <= wrData[3:0];
        end else begin
            if (match[0]) pinLatch_r[0] <= ~pinLatch_r[0];
            for (int c = 1; c < 4; c++) begin
                if (mode_r[MODE_PWM_B + c - 1]) begin
                    if (match[c]) pinLatch_r[c] <= 1'b1;
                    else if (match[0]) pinLatch_r[c] <= 1'b0;
                end else if (match[c]) begin
                    pinLatch_r[c] <= ~pinLatch_r[c];
                end
            end
        end
    end

    // pin reflects the latch directly, so a level write shows next cycle
    assign timerPin = pinLatch_r;

    assign stat = {overflowFlag_r, 3'h7, matchFlag_r};

    // status flags: set wins over clear; clear needs prior read while set
    always_ff @(posedge mclk) begin
        if (rst) begin
            overflowFlag_r <= 1'b0;
            matchFlag_r <= 4'h0;
            armed_r <= 5'h00;
        end else begin
            if (rdStb && addr == ADDR_STAT) begin
                armed_r <= armed_r | {overflowFlag_r, matchFlag_r};
            end
            if (wrap) begin
                overflowFlag_r <= 1'b1;
            end else if (wrStb && addr == ADDR_STAT && !wrData[IEN_OVF] && armed_r[4]) begin
                overflowFlag_r <= 1'b0;
                armed_r[4] <= 1'b0;
            end
            for (int c = 0; c < 4; c++) begin
                if (match[c]) begin
                    matchFlag_r[c] <= 1'b1;
                end else if (wrStb && addr == ADDR_STAT && !wrData[c] && armed_r[c]) begin
                    matchFlag_r[c] <= 1'b0;
                    armed_r[c] <= 1'b0;
                end
            end
        end
    end

    // interrupt requests
    assign overflowIrqReq = overflowFlag_r & ien_r[IEN_OVF];
    assign chanIrqReq = matchFlag_r & ien_r[3:0];

    // read data, one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdStb) begin
            case (addr)
                ADDR_MODE: rdData <= mode_r | MODE_FIXED_ONES;
                ADDR_CTRL: rdData <= ctrl_r;
                ADDR_IEN: rdData <= ien_r | IEN_FIXED_ONES;
                ADDR_STAT: rdData <= stat;
                ADDR_CNT_H: rdData <= count_r[15:8];
                ADDR_CNT_L: rdData <= count_r[7:0];
                default: begin
                    if (addr >= ADDR_GR_BASE) begin
                        rdData <= addr[0] ? genReg_r[addr[2:1]][7:0]
                                          : genReg_r[addr[2:1]][15:8];
                    end else begin
                        rdData <= 8'h00;
                    end
                end
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end

    property p_ovf_req;
        @(posedge mclk) disable iff (rst)
        overflowIrqReq == (overflowFlag_r && ien_r[IEN_OVF]);
    endproperty
    a_ovf_req: assert property (p_ovf_req) else $error("overflow request mismatch");

    property p_wrap_sets;
        @(posedge mclk) disable iff (rst) wrap |=> overflowFlag_r;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("wrap did not set flag");

    property p_halt;
        @(posedge mclk) disable iff (rst)
        (!mode_r[MODE_START] && !wrStb) |=> count_r == $past(count_r);
    endproperty
    a_halt: assert property (p_halt) else $error("count moved while halted");

    property p_clear_a;
        @(posedge mclk) disable iff (rst)
        (ctrl_r[CTRL_CLEAR] && match[0] && !wrStb) |=> count_r == 16'h0000;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("match A did not clear");

    property p_level;
        @(posedge mclk) disable iff (rst)
        (wrStb && addr == ADDR_CTRL) |=> timerPin == $past(wrData[3:0]);
    endproperty
    a_level: assert property (p_level) else $error("level write not on pins");

    property p_ien_rd;
        @(posedge mclk) disable iff (rst)
        (rdStb && addr == ADDR_IEN) |=> rdData[6:4] == 3'h7;
    endproperty
    a_ien_rd: assert property (p_ien_rd) else $error("reserved bits not one");

    property p_noclear_unread;
        @(posedge mclk) disable iff (rst)
        (matchFlag_r[0] && !armed_r[0]) |=> matchFlag_r[0];
    endproperty
    a_noclear_unread: assert property (p_noclear_unread) else $error("flag cleared unread");

    property p_chan_req;
        @(posedge mclk) disable iff (rst) chanIrqReq == (matchFlag_r & ien_r[3:0]);
    endproperty
    a_chan_req: assert property (p_chan_req) else $error("channel request mismatch");

    property p_div8;
        @(posedge mclk) disable iff (rst)
        (mode_r[MODE_START] && clkSel == CKS_DIV8 && countTick) |=> (!countTick || clkSel != CKS_DIV8) [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight wrong");

    property p_pwm_c;
        @(posedge mclk) disable iff (rst)
        (mode_r[MODE_PWM_C] && match[2] && !(wrStb && addr == ADDR_CTRL)) |=> timerPin[2];
    endproperty
    a_pwm_c: assert property (p_pwm_c) else $error("pwm pin C not set at match");

    property p_norm_b;
        @(posedge mclk) disable iff (rst)
        (!mode_r[MODE_PWM_B] && match[1] && !(wrStb && addr == ADDR_CTRL))
            |=> timerPin[1] != $past(timerPin[1]);
    endproperty
    a_norm_b: assert property (p_norm_b) else $error("normal pin B not toggled");

    property p_pwm_d;
        @(posedge mclk) disable iff (rst)
        (mode_r[MODE_PWM_D] && match[0] && !match[3] && !(wrStb && addr == ADDR_CTRL))
            |=> !timerPin[3];
    endproperty
    a_pwm_d: assert property (p_pwm_d) else $error("pwm pin D not reset at period");

    property p_free_run;
        @(posedge mclk) disable iff (rst)
        (countTick && !ctrl_r[CTRL_CLEAR] && !wrStb)
            |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free count did not advance");

    property p_ext_only;
        @(posedge mclk) disable iff (rst)
        (clkSel[2] && !(evSync_r[1] && !evPrev_r)) |-> !countTick;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("tick without event edge");

    property p_sub_only;
        @(posedge mclk) disable iff (rst)
        (clkSel == CKS_DIV1 && subModeSync_r[1] && !(subSync_r[1] && !subPrev_r))
            |-> !countTick;
    endproperty
    a_sub_only: assert property (p_sub_only) else $error("tick without subclock edge");

    property p_div4;
        @(posedge mclk) disable iff (rst)
        (mode_r[MODE_START] && clkSel == CKS_DIV4 && countTick)
            |=> (!countTick || clkSel != CKS_DIV4) [*3];
    endproperty
    a_div4: assert property (p_div4) else $error("divide by four wrong");

    property p_reset_vals;
        @(posedge mclk) rst |=> (mode_r == 8'h00 && ien_r == 8'h00 && timerPin == 4'h0);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
endmodule // tmw_timer

// File: verif/test_timer_w_mode_control_irq_enable.sv
`timescale 1ns/1ps
// self-checking bench for the timer mode, control and enable logic
module test_timer_w_mode_control_irq_enable
    import tmw_pkg::*;
;
    logic mclk, rst, wrStb, rdStb, rdPend; // clock, reset, bus strobes, read note armed
    logic externalEventIn, subClockTick, subMode; // pin-side stimulus
    logic [3:0] addr, timerPin, chanIrqReq;
    logic [7:0] wrData, rdData, rnd; // rnd: lfsr state, reaches levels and enables
    logic overflowIrqReq;
    logic [15:0] expQ[$]; // read notes: tolerance in the top byte, value below
    logic [15:0] note;
    int fails, n_tests;

    tmw_timer dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .externalEventIn(externalEventIn),
        .subClockTick(subClockTick), .subMode(subMode), .timerPin(timerPin),
        .overflowIrqReq(overflowIrqReq), .chanIrqReq(chanIrqReq));

    // 100 ns period
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // small feedback shift register, fixed start value
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // tolerance only for counts, where prescaler phase shifts the result by a tick
    task automatic check(string what, logic [7:0] got, logic [7:0] exp, int tol);
        int d;
        d = int'(got) - int'(exp);
        n_tests++;
        if (got !== exp && ($isunknown(got) || d > tol || d < -tol)) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge mclk) rdPend <= rdStb;
    // compare mid-cycle so the design's update has landed
    always @(negedge mclk) begin
        if (rdPend === 1'b1) begin
            note = expQ.pop_front();
            check("rdData", rdData, note[7:0], int'(note[15:8]));
        end
    end

    // one-cycle write strobe
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask

    // one-cycle read strobe, expectation noted for the watcher
    task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] tol = 8'h00);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        expQ.push_back({tol, e});
        @(posedge mclk);
        rdStb <= 1'b0;
    endtask

    // hi byte first; bytes are independent so order is only habit
    task automatic setCount(logic [15:0] v);
        wr(ADDR_CNT_H, v[15:8]);
        wr(ADDR_CNT_L, v[7:0]);
    endtask

    task automatic setGr(int ch, logic [15:0] v);
        wr(ADDR_GR_BASE + 4'(ch * 2), v[15:8]);
        wr(ADDR_GR_BASE + 4'(ch * 2 + 1), v[7:0]);
    endtask

    // six slow rising edges on the event pin or the subclock
    task automatic edges(logic useExt);
        for (int i = 0; i < 6; i++) begin
            repeat (4) @(posedge mclk);
            if (useExt) externalEventIn <= 1'b1;
            else subClockTick <= 1'b1;
            repeat (4) @(posedge mclk);
            externalEventIn <= 1'b0;
            subClockTick <= 1'b0;
        end
        repeat (4) @(posedge mclk);
    endtask

    // count 0 to about 0x32 past matches at 0x10 (b..d) and 0x20 (a)
    task automatic matchRun(logic [2:0] pwm);
        wr(ADDR_MODE, {5'h00, pwm});
        wr(ADDR_CTRL, 8'h00);
        setCount(16'h0000);
        setGr(0, 16'h0020);
        for (int c = 1; c < 4; c++) setGr(c, 16'h0010);
        wr(ADDR_MODE, {5'h10, pwm});
        repeat (48) @(posedge mclk);
        wr(ADDR_MODE, {5'h00, pwm});
        // normal pins toggle once; pwm pins set at own match, cleared at match a
        #1 check("timerPin", {4'h0, timerPin}, {4'h0, ~pwm, 1'b1}, 0);
        rd(ADDR_STAT, 8'h7f);
        wr(ADDR_STAT, 8'h00);
    endtask

    // pass message only with no mismatch and at least one comparison
    task automatic stop_test();
        $display("counts: %0d comparisons, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog sized well above the roughly 1260 cycles the tests need
    initial begin
        repeat (8000) @(posedge mclk);
        fails++;
        stop_test();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wrData = 8'h00;
        wrStb = 1'b0;
        rdStb = 1'b0;
        externalEventIn = 1'b0;
        subClockTick = 1'b0;
        subMode = 1'b0;
        rnd = 8'h5d;
        fails = 0;
        n_tests = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // reset values, fixed ones, unmapped slot
        rd(ADDR_MODE, MODE_FIXED_ONES);
        rd(ADDR_CTRL, 8'h00);
        rd(ADDR_IEN, IEN_FIXED_ONES);
        rd(ADDR_STAT, 8'h70);
        rd(4'h6, 8'h00);
        wr(ADDR_IEN, 8'h00);
        rd(ADDR_IEN, 8'h70);
        $display("test reset_values done");
        // level bits go straight to the pins
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(ADDR_CTRL, {4'h0, rnd[3:0]});
            #1 check("timerPin", {4'h0, timerPin}, {4'h0, rnd[3:0]}, 0);
        end
        $display("test level_bits done");
        // wrap through ffff: overflow plus all matches at reset compare value
        rnd = lfsr(rnd);
        wr(ADDR_IEN, rnd);
        rd(ADDR_IEN, rnd | 8'h70);
        wr(ADDR_CTRL, 8'h00);
        setCount(16'hfff0);
        wr(ADDR_MODE, 8'h80);
        repeat (24) @(posedge mclk);
        wr(ADDR_MODE, 8'h00);
        #1 check("overflowIrqReq", {7'h0, overflowIrqReq}, {7'h0, rnd[7]}, 0);
        check("chanIrqReq", {4'h0, chanIrqReq}, {4'h0, rnd[3:0]}, 0);
        // flip every enable so each request is seen both masked and raised
        wr(ADDR_IEN, ~rnd);
        #1 check("overflowIrqReq", {7'h0, overflowIrqReq}, {7'h0, ~rnd[7]}, 0);
        check("chanIrqReq", {4'h0, chanIrqReq}, {4'h0, ~rnd[3:0]}, 0);
        wr(ADDR_STAT, 8'h00);
        rd(ADDR_STAT, 8'hff);
        wr(ADDR_STAT, 8'h00);
        rd(ADDR_STAT, 8'h70);
        #1 check("irqAfterClear", {3'h0, overflowIrqReq, chanIrqReq}, 8'h00, 0);
        $display("test overflow_irq done");
        // every pwm select combination
        for (int p = 0; p < 8; p++) matchRun(3'(p));
        $display("test pwm_select done");
        // clear on match a keeps the count at or below 0x10
        wr(ADDR_CTRL, 8'h80);
        setGr(0, 16'h0010);
        // start below the compare value, else the count runs free up to the wrap
        setCount(16'h0000);
        wr(ADDR_MODE, 8'h80);
        repeat (64) @(posedge mclk);
        rd(ADDR_CNT_H, 8'h00);
        rd(ADDR_CNT_L, 8'h08, 8'h08);
        $display("test clear_on_match done");
        // prescaler codes; start and stop writes 66 edges apart
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MODE, 8'h00);
            wr(ADDR_CTRL, {1'b0, 3'(c), 4'h0});
            setCount(16'h0000);
            wr(ADDR_MODE, 8'h80);
            repeat (64) @(posedge mclk);
            wr(ADDR_MODE, 8'h00);
            rd(ADDR_CNT_L, 8'(66 >> c), 8'h02);
        end
        $display("test prescaler done");
        // event pin, then subclock in sub mode; mclk itself must not count
        for (int s = 0; s < 2; s++) begin
            // lower select bits random: the event source ignores them
            rnd = lfsr(rnd);
            wr(ADDR_CTRL, (s == 0) ? {2'b01, rnd[1:0], 4'h0} : 8'h00);
            subMode <= (s == 1);
            setCount(16'h0000);
            wr(ADDR_MODE, 8'h80);
            edges(s == 0);
            wr(ADDR_MODE, 8'h00);
            rd(ADDR_CNT_L, 8'h06);
        end
        $display("test event_sources done");
        repeat (4) @(posedge mclk);
        stop_test();
    end
endmodule // test_timer_w_mode_control_irq_enable
